// [pth_press_handshake.v]
// How it works
// - Press free goes high to let the upstream loader start sending.
// - Press loaded from the loader says the whole batch has moved in.
// - Unload request goes high while a pressed batch is offered down.
// - Cancel from the partner stops the transfer under way after the two-stage pin synchroniser, three pclk edges later.
// - Not-completed is just the inverse of completed, never an error.
// - Data valid means batch data lines are settled and may be read.
// - Without a data valid line, another handshake qualifies the data.
// - Load request tells the loader the press wants a batch soon.
// - Send able tells the receiver the press is now able to send.
`timescale 1ns/1ps
`include "pth_map.vh"

module pth_press_handshake (
	input  wire                   pclk,
	input  wire                   presetn,
	input  wire                   psel,
	input  wire                   penable,
	input  wire                   pwrite,
	input  wire [11:0]            paddr,
	input  wire [31:0]            pwdata,
	output reg  [31:0]            prdata,
	output wire                   pready,
	output wire                   pslverr,
	output wire                   irq,
	input  wire                   press_loaded,
	input  wire                   up_unload_request,
	input  wire                   up_send_able,
	input  wire                   start_discharge,
	input  wire                   cancel_transfer,
	input  wire                   dn_load_request,
	input  wire [`PTH_DATA_W-1:0] load_batch_data,
	output reg                    press_free,
	output reg                    load_request_out,
	output reg                    unload_request_out,
	output reg                    send_able_out,
	output reg                    discharge_data_valid,
	output reg                    transfer_complete_out,
	output reg                    transfer_not_complete,
	output reg                    discharge_active,
	output reg  [`PTH_DATA_W-1:0] discharge_data
);

	// ----------------------------------------
	// State codes
	// ----------------------------------------
	localparam [1:0] L_IDLE = 2'h0;
	localparam [1:0] L_FREE = 2'h1;
	localparam [1:0] L_FULL = 2'h2;

	localparam [1:0] D_IDLE  = 2'h0;
	localparam [1:0] D_OFFER = 2'h1;
	localparam [1:0] D_SEND  = 2'h2;
	localparam [1:0] D_DONE  = 2'h3;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	reg  [2:0]              ctrl;
	reg  [1:0]              load_state;
	reg  [1:0]              next_load_state;
	reg  [1:0]              dis_state;
	reg  [1:0]              next_dis_state;
	reg  [`PTH_DATA_W-1:0]  load_data;
	reg  [`PTH_PIN_W-1:0]   pins_prev;
	reg  [`PTH_EV_W-1:0]    events;
	wire [`PTH_PIN_W-1:0]   pins_raw;
	wire [`PTH_PIN_W-1:0]   pins;
	wire [`PTH_DATA_W-1:0]  data_sync;
	wire [`PTH_EV_W-1:0]    irq_status;
	wire [`PTH_EV_W-1:0]    irq_mask;
	wire                    wr_en;
	wire                    rd_en;
	wire                    addr_hit;
	wire                    cmd_wr;
	wire                    arm_load;
	wire                    offer;
	wire                    dis_done;
	wire                    abort;
	wire                    en;
	wire                    s_loaded;
	wire                    s_up_req;
	wire                    s_up_able;
	wire                    s_start;
	wire                    s_cancel;
	wire                    s_dn_req;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Rising edge of a synchronised level
	function rise;
		input prev;
		input cur;
		begin
			rise = cur & ~prev;
		end
	endfunction

	// Offset decode for a register word
	function hit;
		input [11:0] addr;
		input [11:0] ofs;
		begin
			hit = (addr == ofs);
		end
	endfunction

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	// Partner pins are asynchronous to pclk
	assign pins_raw = {dn_load_request, cancel_transfer, start_discharge,
		up_send_able, up_unload_request, press_loaded};

	pth_sync #(
		.W (`PTH_PIN_W)
	) u_pin_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (pins_raw),
		.sync_out (pins)
	);

	// Batch code lines from the loader
	pth_sync #(
		.W (`PTH_DATA_W)
	) u_data_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (load_batch_data),
		.sync_out (data_sync)
	);

	assign s_loaded  = pins[0];
	assign s_up_req  = pins[1];
	assign s_up_able = pins[2];
	assign s_start   = pins[3];
	assign s_cancel  = pins[4];
	assign s_dn_req  = pins[5];

	// Previous pin levels for edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_prev <= {`PTH_PIN_W{1'b0}};
		end else begin
			pins_prev <= pins;
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; unmapped offsets error
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & ~pwrite;
	assign pready  = 1'b1;
	assign addr_hit = hit(paddr, `PTH_CTRL_OFS)
		| hit(paddr, `PTH_CMD_OFS)
		| hit(paddr, `PTH_STATUS_OFS)
		| hit(paddr, `PTH_IRQ_STAT_OFS)
		| hit(paddr, `PTH_IRQ_MASK_OFS)
		| hit(paddr, `PTH_LOAD_DATA_OFS)
		| hit(paddr, `PTH_DIS_DATA_OFS);
	assign pslverr = psel & penable & ~addr_hit;

	// Command strobes, one cycle each
	assign cmd_wr   = wr_en & hit(paddr, `PTH_CMD_OFS);
	assign arm_load = cmd_wr & pwdata[`PTH_CMD_ARM_LOAD];
	assign offer    = cmd_wr & pwdata[`PTH_CMD_OFFER];
	assign dis_done = cmd_wr & pwdata[`PTH_CMD_DIS_DONE];
	assign abort    = cmd_wr & pwdata[`PTH_CMD_ABORT];
	assign en       = ctrl[`PTH_CTRL_EN];

	// Control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `PTH_CTRL_RST;
		end else if (wr_en & hit(paddr, `PTH_CTRL_OFS)) begin
			ctrl <= pwdata[2:0];
		end
	end

	// Data for the receiver, held while sending
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			discharge_data <= `PTH_DATA_RST;
		end else if (wr_en & hit(paddr, `PTH_DIS_DATA_OFS)
			& (dis_state == D_IDLE)) begin
			discharge_data <= pwdata[`PTH_DATA_W-1:0];
		end
	end

	// Read data, registered in the setup cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en & ~penable) begin
			prdata <= 32'h0000_0000;
			if (hit(paddr, `PTH_CTRL_OFS)) begin
				prdata[2:0] <= ctrl;
			end
			if (hit(paddr, `PTH_STATUS_OFS)) begin
				prdata[1:0]  <= load_state;
				prdata[3:2]  <= dis_state;
				prdata[9:4]  <= pins;
			end
			if (hit(paddr, `PTH_IRQ_STAT_OFS)) begin
				prdata[`PTH_EV_W-1:0] <= irq_status;
			end
			if (hit(paddr, `PTH_IRQ_MASK_OFS)) begin
				prdata[`PTH_EV_W-1:0] <= irq_mask;
			end
			if (hit(paddr, `PTH_LOAD_DATA_OFS)) begin
				prdata[`PTH_DATA_W-1:0] <= load_data;
			end
			if (hit(paddr, `PTH_DIS_DATA_OFS)) begin
				prdata[`PTH_DATA_W-1:0] <= discharge_data;
			end
		end
	end

	// ----------------------------------------
	// Loading side
	// ----------------------------------------
	// Next loading state
	always @* begin
		next_load_state = load_state;
		case (load_state)
			L_IDLE: begin
				if (en & arm_load & ~s_loaded) begin
					next_load_state = L_FREE;
				end
			end
			L_FREE: begin
				if (~en | abort | s_cancel) begin
					next_load_state = L_IDLE;
				end else if (s_loaded) begin
					next_load_state = L_FULL;
				end
			end
			L_FULL: begin
				if (~s_loaded) begin
					next_load_state = L_IDLE;
				end
			end
			default: begin
				next_load_state = L_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_state <= L_IDLE;
		end else begin
			load_state <= next_load_state;
		end
	end

	// Batch code taken as press loaded rises
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			load_data <= `PTH_DATA_RST;
		end else if ((load_state == L_FREE)
			& rise(pins_prev[0], s_loaded)) begin
			load_data <= data_sync;
		end
	end

	// Loading outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			press_free       <= 1'b0;
			load_request_out <= 1'b0;
		end else begin
			press_free <= (next_load_state == L_FREE);
			load_request_out <= en & ctrl[`PTH_CTRL_LOAD_WANT]
				& (next_load_state != L_FULL);
		end
	end

	// ----------------------------------------
	// Discharge side
	// ----------------------------------------
	// Next discharge state
	always @* begin
		next_dis_state = dis_state;
		case (dis_state)
			D_IDLE: begin
				if (en & offer) begin
					next_dis_state = D_OFFER;
				end
			end
			D_OFFER: begin
				if (~en | abort | s_cancel) begin
					next_dis_state = D_IDLE;
				end else if (s_start & ctrl[`PTH_CTRL_SEND_ABLE]) begin
					next_dis_state = D_SEND;
				end
			end
			D_SEND: begin
				if (~en | abort | s_cancel) begin
					next_dis_state = D_IDLE;
				end else if (dis_done) begin
					next_dis_state = D_DONE;
				end
			end
			D_DONE: begin
				if (~s_start | ~en) begin
					next_dis_state = D_IDLE;
				end
			end
			default: begin
				next_dis_state = D_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_state <= D_IDLE;
		end else begin
			dis_state <= next_dis_state;
		end
	end

	// Discharge outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unload_request_out    <= 1'b0;
			send_able_out         <= 1'b0;
			discharge_active      <= 1'b0;
			discharge_data_valid  <= 1'b0;
			transfer_complete_out <= 1'b0;
			transfer_not_complete <= 1'b1;
		end else begin
			unload_request_out <= (next_dis_state == D_OFFER)
				| (next_dis_state == D_SEND);
			send_able_out <= ctrl[`PTH_CTRL_SEND_ABLE]
				& ((next_dis_state == D_OFFER)
				| (next_dis_state == D_SEND));
			discharge_active <= (next_dis_state == D_SEND);
			discharge_data_valid <= (next_dis_state != D_IDLE);
			transfer_complete_out <= (next_dis_state == D_DONE);
			transfer_not_complete <= (next_dis_state != D_DONE);
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	// One-cycle event pulses
	always @* begin
		events = {`PTH_EV_W{1'b0}};
		events[`PTH_EV_LOADED] = (load_state == L_FREE)
			& (next_load_state == L_FULL);
		events[`PTH_EV_DIS_START] = (dis_state == D_OFFER)
			& (next_dis_state == D_SEND);
		events[`PTH_EV_DIS_DONE] = (dis_state == D_SEND)
			& (next_dis_state == D_DONE);
		events[`PTH_EV_CANCEL] = s_cancel
			& ((load_state == L_FREE) | (dis_state == D_OFFER)
			| (dis_state == D_SEND));
		events[`PTH_EV_UP_OFFER] = rise(pins_prev[1], s_up_req)
			| rise(pins_prev[2], s_up_able);
		events[`PTH_EV_DN_READY] = rise(pins_prev[5], s_dn_req);
	end

	pth_irq u_irq (
		.pclk     (pclk),
		.presetn  (presetn),
		.event_in (events),
		.stat_wr  (wr_en & hit(paddr, `PTH_IRQ_STAT_OFS)),
		.mask_wr  (wr_en & hit(paddr, `PTH_IRQ_MASK_OFS)),
		.wdata    (pwdata[`PTH_EV_W-1:0]),
		.status   (irq_status),
		.mask     (irq_mask),
		.irq      (irq)
	);

endmodule

// [pth_map.vh]
`ifndef PTH_MAP_VH
`define PTH_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PTH_CTRL_OFS      12'h000
`define PTH_CMD_OFS       12'h004
`define PTH_STATUS_OFS    12'h008
`define PTH_IRQ_STAT_OFS  12'h00c
`define PTH_IRQ_MASK_OFS  12'h010
`define PTH_LOAD_DATA_OFS 12'h014
`define PTH_DIS_DATA_OFS  12'h018

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PTH_CTRL_EN       0
`define PTH_CTRL_LOAD_WANT 1
`define PTH_CTRL_SEND_ABLE 2
`define PTH_CTRL_RST      3'h0

// ----------------------------------------
// Command fields (write one to act)
// ----------------------------------------
`define PTH_CMD_ARM_LOAD  0
`define PTH_CMD_OFFER     1
`define PTH_CMD_DIS_DONE  2
`define PTH_CMD_ABORT     3

// ----------------------------------------
// Event bits of status and mask
// ----------------------------------------
`define PTH_EV_LOADED     0
`define PTH_EV_DIS_START  1
`define PTH_EV_DIS_DONE   2
`define PTH_EV_CANCEL     3
`define PTH_EV_UP_OFFER   4
`define PTH_EV_DN_READY   5
`define PTH_EV_W          6
`define PTH_MASK_RST      6'h00

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define PTH_DATA_W        8
`define PTH_DATA_RST      8'h00
`define PTH_PIN_W         6

`endif

// [pth_sync.v]
`timescale 1ns/1ps

module pth_sync #(
	parameter W = 1
) (
	input  wire         pclk,
	input  wire         presetn,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);

	reg [W-1:0] stage1;

	// ----------------------------------------
	// Two flip-flop level synchroniser
	// ----------------------------------------
	// First stage is read only by the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// [pth_irq.v]
`timescale 1ns/1ps
`include "pth_map.vh"

module pth_irq (
	input  wire                  pclk,
	input  wire                  presetn,
	input  wire [`PTH_EV_W-1:0]  event_in,
	input  wire                  stat_wr,
	input  wire                  mask_wr,
	input  wire [`PTH_EV_W-1:0]  wdata,
	output reg  [`PTH_EV_W-1:0]  status,
	output reg  [`PTH_EV_W-1:0]  mask,
	output reg                   irq
);

	// ----------------------------------------
	// Sticky status, write one to clear
	// ----------------------------------------
	// A new event wins over a clear in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= {`PTH_EV_W{1'b0}};
		end else if (stat_wr) begin
			status <= (status & ~wdata) | event_in;
		end else begin
			status <= status | event_in;
		end
	end

	// Mask register, one enables a source
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= `PTH_MASK_RST;
		end else if (mask_wr) begin
			mask <= wdata;
		end
	end

	// Level interrupt from any unmasked bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

endmodule

// [pth_chk.sv]
`timescale 1ns/1ps
// Checks the handshake outputs against the partner pins
module pth_chk (
	input wire       pclk,
	input wire       presetn,
	input wire       psel,
	input wire       penable,
	input wire       pslverr,
	input wire       press_loaded,
	input wire       start_discharge,
	input wire       cancel_transfer,
	input wire       press_free,
	input wire       unload_request_out,
	input wire       send_able_out,
	input wire       discharge_data_valid,
	input wire       transfer_complete_out,
	input wire       transfer_not_complete,
	input wire       discharge_active,
	input wire [7:0] discharge_data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Partner steps
	sequence s_loaded;
		press_free && press_loaded;
	endsequence
	sequence s_cancel;
		$rose(cancel_transfer);
	endsequence
	sequence s_quiet;
		!unload_request_out && !press_free;
	endsequence
	property p_free_drop;
		s_loaded |-> ##[1:5] !press_free;
	endproperty
	a_free_drop: assert property (p_free_drop)
		else $error("press free held after loaded");
	property p_cancel;
		s_cancel |-> ##[1:5] s_quiet;
	endproperty
	a_cancel: assert property (p_cancel)
		else $error("transfer kept after cancel");
	property p_start;
		$rose(discharge_active) |->
			$past(start_discharge) && $past(unload_request_out);
	endproperty
	a_start: assert property (p_start)
		else $error("discharge without start");
	property p_done;
		$rose(transfer_complete_out) |->
			$past(discharge_active) && !unload_request_out;
	endproperty
	a_done: assert property (p_done)
		else $error("complete out of order");
	property p_inv;
		transfer_not_complete != transfer_complete_out;
	endproperty
	a_inv: assert property (p_inv)
		else $error("not complete is not inverse");
	property p_valid;
		unload_request_out |-> discharge_data_valid;
	endproperty
	a_valid: assert property (p_valid)
		else $error("offer without data valid");
	property p_able;
		send_able_out |-> unload_request_out;
	endproperty
	a_able: assert property (p_able)
		else $error("send able outside offer");
	property p_stable;
		discharge_data_valid && $past(discharge_data_valid)
			|-> $stable(discharge_data);
	endproperty
	a_stable: assert property (p_stable)
		else $error("data moved while valid");
	property p_err;
		pslverr |-> psel && penable;
	endproperty
	a_err: assert property (p_err)
		else $error("slave error outside access");
endmodule

// [pth_far.sv]
`timescale 1ns/1ps
// Allied loader upstream and receiver downstream
module pth_far (
	input  wire       pclk,
	input  wire       press_free,
	input  wire       unload_request_out,
	input  wire       transfer_complete_out,
	output reg        press_loaded,
	output reg        up_unload_request,
	output reg        up_send_able,
	output reg        start_discharge,
	output reg        cancel_transfer,
	output reg        dn_load_request,
	output reg  [7:0] load_batch_data
);
	int n;
	// Idle levels
	initial begin
		{press_loaded, up_unload_request, up_send_able} = 3'h0;
		{start_discharge, cancel_transfer, dn_load_request} = 3'h0;
		load_batch_data = 8'hff;
	end
	// Loader sends one batch once the press is free
	task automatic load(input [7:0] d);
		@(posedge pclk);
		up_unload_request <= 1'b1;
		up_send_able <= 1'b1;
		for (n = 0; n < 40 && press_free !== 1'b1; n++) @(posedge pclk);
		load_batch_data <= d;
		repeat (3) @(posedge pclk);
		press_loaded <= 1'b1;
		for (n = 0; n < 40 && press_free !== 1'b0; n++) @(posedge pclk);
		@(posedge pclk);
		{up_unload_request, up_send_able} <= 2'h0;
	endtask
	// Loader drops press loaded after the press took the batch
	task automatic drop_loaded();
		@(posedge pclk);
		press_loaded <= 1'b0;
		load_batch_data <= ~load_batch_data; // Released lines drift
	endtask
	// Receiver starts after dly cycles, drops on complete
	task automatic take(input int dly);
		@(posedge pclk);
		dn_load_request <= 1'b1;
		for (n = 0; n < 40 && unload_request_out !== 1'b1; n++)
			@(posedge pclk);
		repeat (dly) @(posedge pclk);
		start_discharge <= 1'b1;
		for (n = 0; n < 200 && transfer_complete_out !== 1'b1; n++)
			@(posedge pclk);
		@(posedge pclk);
		{start_discharge, dn_load_request} <= 2'h0;
	endtask
	// Partner cancels the transfer under way
	task automatic stop_it();
		@(posedge pclk);
		cancel_transfer <= 1'b1;
		repeat (4) @(posedge pclk);
		cancel_transfer <= 1'b0;
	endtask
endmodule

// [pth_press_handshake_test.sv]
`timescale 1ns/1ps
`include "pth_map.vh"
module pth_press_handshake_test;
	reg         pclk = 1'b0;
	reg         presetn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [31:0] rd;
	reg         err;
	wire [31:0] prdata;
	wire [7:0]  load_batch_data, discharge_data;
	wire        pready, pslverr, irq, press_loaded, up_unload_request;
	wire        up_send_able, start_discharge, cancel_transfer;
	wire        dn_load_request, press_free, load_request_out;
	wire        unload_request_out, send_able_out, discharge_data_valid;
	wire        transfer_complete_out, transfer_not_complete;
	wire        discharge_active;
	int         fail_count = 0;
	int         num_checks = 0;
	int         n;
	always #25 pclk = ~pclk;
	pth_press_handshake i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .press_loaded,
		.up_unload_request, .up_send_able, .start_discharge,
		.cancel_transfer, .dn_load_request, .load_batch_data, .press_free,
		.load_request_out, .unload_request_out, .send_able_out,
		.discharge_data_valid, .transfer_complete_out,
		.transfer_not_complete, .discharge_active, .discharge_data);
	pth_far i_far (.pclk, .press_free, .unload_request_out,
		.transfer_complete_out, .press_loaded, .up_unload_request,
		.up_send_able, .start_discharge, .cancel_transfer,
		.dn_load_request, .load_batch_data);
	// One APB transfer, held until pready
	task automatic apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk_w(input string s, input [31:0] e, input [31:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_b(input string s, input e, input g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", s, e, g);
		end
	endtask
	task automatic rdc(input [11:0] a, input [31:0] e, input string s);
		apb(1'b0, a, 32'h0);
		chk_w(s, e, rd);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		chk_b("not_complete", 1'b1, transfer_not_complete);
		chk_b("press_free", 1'b0, press_free);
		rdc(`PTH_CTRL_OFS, 32'h0, "ctrl");
		rdc(`PTH_IRQ_MASK_OFS, 32'h0, "mask");
		rdc(`PTH_DIS_DATA_OFS, 32'h0, "dis_data");
		rdc(12'h0fc, 32'h0, "unmapped");
		chk_b("slverr", 1'b1, err);
		apb(1'b1, `PTH_CMD_OFS, 32'h1);
		settle(1);
		chk_b("press_free", 1'b0, press_free);
		// Loading side
		apb(1'b1, `PTH_IRQ_MASK_OFS, 32'h3f);
		apb(1'b1, `PTH_CTRL_OFS, 32'h3);
		settle(1);
		chk_b("load_req", 1'b1, load_request_out);
		apb(1'b1, `PTH_CMD_OFS, 32'h1);
		settle(1);
		chk_b("press_free", 1'b1, press_free);
		i_far.load(8'h5a);
		settle(4);
		chk_b("press_free", 1'b0, press_free);
		chk_b("load_req", 1'b0, load_request_out);
		rdc(`PTH_LOAD_DATA_OFS, 32'h5a, "load_data");
		rdc(`PTH_STATUS_OFS, 32'h12, "status");
		rdc(`PTH_IRQ_STAT_OFS, 32'h11, "irq_stat");
		chk_b("irq", 1'b1, irq);
		apb(1'b1, `PTH_IRQ_STAT_OFS, 32'h3f);
		settle(2);
		chk_b("irq", 1'b0, irq);
		i_far.drop_loaded();
		settle(4);
		chk_b("load_req", 1'b1, load_request_out);
		apb(1'b1, `PTH_IRQ_MASK_OFS, 32'h1);
		// Discharge side, DIS_DATA locked while offered
		apb(1'b1, `PTH_DIS_DATA_OFS, 32'ha5);
		apb(1'b1, `PTH_CTRL_OFS, 32'h5);
		apb(1'b1, `PTH_CMD_OFS, 32'h2);
		apb(1'b1, `PTH_DIS_DATA_OFS, 32'h3c);
		settle(6);
		chk_b("unload_req", 1'b1, unload_request_out);
		chk_b("send_able", 1'b1, send_able_out);
		chk_b("valid", 1'b1, discharge_data_valid);
		chk_w("dis_data", 32'ha5, {24'h0, discharge_data});
		chk_b("active", 1'b0, discharge_active);
		fork
			i_far.take(3);
			begin
				for (n = 0; n < 40 && discharge_active !== 1'b1; n++)
					@(posedge pclk);
				apb(1'b1, `PTH_CMD_OFS, 32'h4);
				settle(1);
				chk_b("complete", 1'b1, transfer_complete_out);
				chk_b("unload_req", 1'b0, unload_request_out);
			end
		join
		settle(5);
		rdc(`PTH_IRQ_STAT_OFS, 32'h26, "irq_stat");
		chk_b("irq_masked", 1'b0, irq);
		// Cancel from the receiver
		apb(1'b1, `PTH_IRQ_STAT_OFS, 32'h3f);
		apb(1'b1, `PTH_CMD_OFS, 32'h2);
		i_far.stop_it();
		settle(4);
		chk_b("unload_req", 1'b0, unload_request_out);
		rdc(`PTH_IRQ_STAT_OFS, 32'h8, "cancel_ev");
		// Offer without send able, then abort
		apb(1'b1, `PTH_CTRL_OFS, 32'h1);
		apb(1'b1, `PTH_CMD_OFS, 32'h2);
		settle(1);
		chk_b("send_able", 1'b0, send_able_out);
		apb(1'b1, `PTH_CMD_OFS, 32'h8);
		settle(1);
		chk_b("valid", 1'b0, discharge_data_valid);
		wrap_up();
	end
endmodule
bind pth_press_handshake pth_chk i_chk (.pclk, .presetn, .psel,
	.penable, .pslverr, .press_loaded, .start_discharge,
	.cancel_transfer, .press_free, .unload_request_out, .send_able_out,
	.discharge_data_valid, .transfer_complete_out,
	.transfer_not_complete, .discharge_active, .discharge_data);
